// file: include/wakeup_measure_compare_pkg.sv
package wakeup_measure_compare_pkg;

  // ****************************************************************
  // register indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [7:0] AMP_CFG_IDX    = 8'h32;
  localparam logic [7:0] AMP_REF_IDX    = 8'h33;
  localparam logic [7:0] AMP_AVG_IDX    = 8'h34;
  localparam logic [7:0] AMP_RES_IDX    = 8'h35;
  localparam logic [7:0] PHS_CFG_IDX    = 8'h36;
  localparam logic [7:0] PHS_REF_IDX    = 8'h37;
  localparam logic [7:0] PHS_AVG_IDX    = 8'h38;
  localparam logic [7:0] PHS_RES_IDX    = 8'h39;
  localparam logic [7:0] CAP_CFG_IDX    = 8'h3A;
  localparam logic [7:0] CAP_REF_IDX    = 8'h3B;
  localparam logic [7:0] CAP_AVG_IDX    = 8'h3C;
  localparam logic [7:0] CAP_RES_IDX    = 8'h3D;
  localparam logic [7:0] WAKE_CTRL_IDX  = 8'h40;
  localparam logic [7:0] IRQ_STATUS_IDX = 8'h41;
  localparam logic [7:0] IRQ_MASK_IDX   = 8'h42;
  localparam logic [7:0] COMMAND_IDX    = 8'h43;

  // ****************************************************************
  // field layout of a measurement configuration register
  // ****************************************************************
  localparam int THRESHOLD_MSB = 7;
  localparam int THRESHOLD_LSB = 4;
  localparam int FOLD_BIT      = 3;
  localparam int WEIGHT_MSB    = 2;
  localparam int WEIGHT_LSB    = 1;
  localparam int SOURCE_BIT    = 0;
  localparam logic [2:0] WEIGHT_SHIFT_BASE = 3'h2;   // code 00 means weight 4

  // ****************************************************************
  // channels, control and command bits, reset values
  // ****************************************************************
  localparam int CH_AMP = 0;
  localparam int CH_PHS = 1;
  localparam int CH_CAP = 2;
  localparam int NUM_CH = 3;
  localparam int CMD_DEFAULT_BIT = 0;
  localparam logic [7:0]  REG_RESET  = 8'h00;
  localparam logic [31:0] READ_ZERO  = 32'h0000_0000;

  typedef enum logic [1:0] {
    seq_idle,
    seq_issue,
    seq_wait
  } seq_state_t;

endpackage : wakeup_measure_compare_pkg

// file: hdl/wakeup_measure_compare.sv
`timescale 1ns/1ps

// Functional notes
// - phase threshold in upper nibble raises interrupt
// - capacitance threshold in upper nibble raises interrupt
// - bit 3 folds triggering sample into average
// - bits 2:1 weight codes give 4/8/16/32
// - phase bit 0 picks reference or average
// - capacitance bit 0 picks reference or average
// - writable amplitude reference at 33h
// - writable phase reference at 37h
// - amplitude average 34h, result 35h, read-only
// - phase average 38h, result 39h, read-only
// - config and references zero on reset/default
// - result and average views zero likewise
// - timer expiry runs enabled measurements, compares
// - amplitude config shares the phase layout
module wakeup_measure_compare (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // wake-up timer and measurement front end
  input  wire logic        timer_expiry,
  input  wire logic        meas_done,
  input  wire logic [7:0]  meas_value,
  output logic             meas_start,
  output logic [1:0]       meas_channel,
  // interrupt
  output logic             irq
);

  // ****************************************************************
  // registers and state
  // ****************************************************************
  logic [7:0] cfg      [wakeup_measure_compare_pkg::NUM_CH];
  logic [7:0] baseline [wakeup_measure_compare_pkg::NUM_CH];
  logic [7:0] mean     [wakeup_measure_compare_pkg::NUM_CH];
  logic [7:0] latest   [wakeup_measure_compare_pkg::NUM_CH];
  logic [2:0] wake_enable;
  logic [2:0] irq_status;
  logic [2:0] irq_mask;
  logic [2:0] pending;
  wakeup_measure_compare_pkg::seq_state_t seq_state;

  // ****************************************************************
  // bus decode
  // ****************************************************************
  logic       access;
  logic       commit_wr;
  logic       addr_ok;
  logic [7:0] idx;
  logic       set_default;
  logic       take;
  logic [2:0] take_ch;
  logic [2:0] hit;
  logic [7:0] next_mean [wakeup_measure_compare_pkg::NUM_CH];
  logic [7:0] sel_ref   [wakeup_measure_compare_pkg::NUM_CH];
  logic [7:0] abs_diff  [wakeup_measure_compare_pkg::NUM_CH];

  // access phase, a committed write, and the register index
  assign access    = psel & penable;
  assign commit_wr = access & pready & pwrite;
  assign idx       = paddr[9:2];
  assign addr_ok   = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0) &&
                     ((idx >= wakeup_measure_compare_pkg::AMP_CFG_IDX &&
                       idx <= wakeup_measure_compare_pkg::CAP_RES_IDX) ||
                      (idx >= wakeup_measure_compare_pkg::WAKE_CTRL_IDX &&
                       idx <= wakeup_measure_compare_pkg::COMMAND_IDX));
  assign set_default = commit_wr && addr_ok &&
                       idx == wakeup_measure_compare_pkg::COMMAND_IDX &&
                       pwdata[wakeup_measure_compare_pkg::CMD_DEFAULT_BIT];

  // a finished measurement is taken only while waiting for it
  assign take = (seq_state == wakeup_measure_compare_pkg::seq_wait) && meas_done;
  assign take_ch = take ? (3'h1 << meas_channel) : 3'h0;

  // ****************************************************************
  // per-channel compare and averaging
  // ****************************************************************
  for (genvar c = 0; c < wakeup_measure_compare_pkg::NUM_CH; c++) begin : g_ch
    logic signed [8:0] ref_delta;
    logic signed [8:0] mean_delta;
    logic signed [8:0] mean_step;
    logic        [2:0] shift;

    // baseline source select, shared layout on all channels
    assign sel_ref[c] = cfg[c][wakeup_measure_compare_pkg::SOURCE_BIT] ? mean[c]
                                                                      : baseline[c];
    // strict greater-than on the absolute difference
    assign ref_delta   = $signed({1'b0, meas_value}) - $signed({1'b0, sel_ref[c]});
    assign abs_diff[c] = ref_delta[8] ? 8'(-ref_delta) : ref_delta[7:0];
    assign hit[c]      = abs_diff[c] > {4'h0, cfg[c][wakeup_measure_compare_pkg::THRESHOLD_MSB:
                                                   wakeup_measure_compare_pkg::THRESHOLD_LSB]};
    // weight code 0..3 shifts the difference by 2..5
    assign shift = wakeup_measure_compare_pkg::WEIGHT_SHIFT_BASE +
                   {1'b0, cfg[c][wakeup_measure_compare_pkg::WEIGHT_MSB:
                                 wakeup_measure_compare_pkg::WEIGHT_LSB]};
    assign mean_delta   = $signed({1'b0, meas_value}) - $signed({1'b0, mean[c]});
    assign mean_step    = mean_delta >>> shift;
    assign next_mean[c] = mean[c] + mean_step[7:0];
  end

  // ****************************************************************
  // apb answer: one wait cycle, registered data and error
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= access & ~pready;
      pslverr <= access & ~pready & ~addr_ok;
    end
  end

  // read multiplexer, captured on the same edge that raises pready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= wakeup_measure_compare_pkg::READ_ZERO;
    end else if (access && !pready && !pwrite && addr_ok) begin
      case (idx)
        wakeup_measure_compare_pkg::AMP_CFG_IDX:    prdata <= {24'h0, cfg[0]};
        wakeup_measure_compare_pkg::AMP_REF_IDX:    prdata <= {24'h0, baseline[0]};
        wakeup_measure_compare_pkg::AMP_AVG_IDX:    prdata <= {24'h0, mean[0]};
        wakeup_measure_compare_pkg::AMP_RES_IDX:    prdata <= {24'h0, latest[0]};
        wakeup_measure_compare_pkg::PHS_CFG_IDX:    prdata <= {24'h0, cfg[1]};
        wakeup_measure_compare_pkg::PHS_REF_IDX:    prdata <= {24'h0, baseline[1]};
        wakeup_measure_compare_pkg::PHS_AVG_IDX:    prdata <= {24'h0, mean[1]};
        wakeup_measure_compare_pkg::PHS_RES_IDX:    prdata <= {24'h0, latest[1]};
        wakeup_measure_compare_pkg::CAP_CFG_IDX:    prdata <= {24'h0, cfg[2]};
        wakeup_measure_compare_pkg::CAP_REF_IDX:    prdata <= {24'h0, baseline[2]};
        wakeup_measure_compare_pkg::CAP_AVG_IDX:    prdata <= {24'h0, mean[2]};
        wakeup_measure_compare_pkg::CAP_RES_IDX:    prdata <= {24'h0, latest[2]};
        wakeup_measure_compare_pkg::WAKE_CTRL_IDX:  prdata <= {29'h0, wake_enable};
        wakeup_measure_compare_pkg::IRQ_STATUS_IDX: prdata <= {29'h0, irq_status};
        wakeup_measure_compare_pkg::IRQ_MASK_IDX:   prdata <= {29'h0, irq_mask};
        default:                                    prdata <= wakeup_measure_compare_pkg::READ_ZERO;
      endcase
    end else if (access && !pready) begin
      prdata <= wakeup_measure_compare_pkg::READ_ZERO;
    end
  end

  // ****************************************************************
  // software-written configuration, references and control
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int c = 0; c < wakeup_measure_compare_pkg::NUM_CH; c++) begin
        cfg[c]      <= wakeup_measure_compare_pkg::REG_RESET;
        baseline[c] <= wakeup_measure_compare_pkg::REG_RESET;
      end
      wake_enable <= 3'h0;
      irq_mask    <= 3'h0;
    end else if (set_default) begin
      for (int c = 0; c < wakeup_measure_compare_pkg::NUM_CH; c++) begin
        cfg[c]      <= wakeup_measure_compare_pkg::REG_RESET;
        baseline[c] <= wakeup_measure_compare_pkg::REG_RESET;
      end
      wake_enable <= 3'h0;
      irq_mask    <= 3'h0;
    end else if (commit_wr && addr_ok) begin
      case (idx)
        wakeup_measure_compare_pkg::AMP_CFG_IDX:   cfg[0]      <= pwdata[7:0];
        wakeup_measure_compare_pkg::AMP_REF_IDX:   baseline[0] <= pwdata[7:0];
        wakeup_measure_compare_pkg::PHS_CFG_IDX:   cfg[1]      <= pwdata[7:0];
        wakeup_measure_compare_pkg::PHS_REF_IDX:   baseline[1] <= pwdata[7:0];
        wakeup_measure_compare_pkg::CAP_CFG_IDX:   cfg[2]      <= pwdata[7:0];
        wakeup_measure_compare_pkg::CAP_REF_IDX:   baseline[2] <= pwdata[7:0];
        wakeup_measure_compare_pkg::WAKE_CTRL_IDX: wake_enable <= pwdata[2:0];
        wakeup_measure_compare_pkg::IRQ_MASK_IDX:  irq_mask    <= pwdata[2:0];
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // measurement sequencer, one request per enabled channel
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_state    <= wakeup_measure_compare_pkg::seq_idle;
      pending      <= 3'h0;
      meas_start   <= 1'b0;
      meas_channel <= 2'h0;
    end else if (set_default) begin
      seq_state  <= wakeup_measure_compare_pkg::seq_idle;
      pending    <= 3'h0;
      meas_start <= 1'b0;
    end else begin
      meas_start <= 1'b0;
      case (seq_state)
        wakeup_measure_compare_pkg::seq_idle: begin
          if (timer_expiry && wake_enable != 3'h0) begin
            pending   <= wake_enable;
            seq_state <= wakeup_measure_compare_pkg::seq_issue;
          end
        end
        wakeup_measure_compare_pkg::seq_issue: begin
          // lowest pending channel first: amplitude, phase, capacitance
          meas_start <= 1'b1;
          seq_state  <= wakeup_measure_compare_pkg::seq_wait;
          if (pending[0]) begin
            meas_channel <= 2'h0;
            pending[0]   <= 1'b0;
          end else if (pending[1]) begin
            meas_channel <= 2'h1;
            pending[1]   <= 1'b0;
          end else begin
            meas_channel <= 2'h2;
            pending[2]   <= 1'b0;
          end
        end
        wakeup_measure_compare_pkg::seq_wait: begin
          if (meas_done) begin
            seq_state <= (pending == 3'h0) ? wakeup_measure_compare_pkg::seq_idle
                                           : wakeup_measure_compare_pkg::seq_issue;
          end
        end
        default: seq_state <= wakeup_measure_compare_pkg::seq_idle;
      endcase
    end
  end

  // ****************************************************************
  // result and running-average views
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int c = 0; c < wakeup_measure_compare_pkg::NUM_CH; c++) begin
        mean[c]   <= wakeup_measure_compare_pkg::REG_RESET;
        latest[c] <= wakeup_measure_compare_pkg::REG_RESET;
      end
    end else if (set_default) begin
      for (int c = 0; c < wakeup_measure_compare_pkg::NUM_CH; c++) begin
        mean[c]   <= wakeup_measure_compare_pkg::REG_RESET;
        latest[c] <= wakeup_measure_compare_pkg::REG_RESET;
      end
    end else begin
      for (int c = 0; c < wakeup_measure_compare_pkg::NUM_CH; c++) begin
        if (take_ch[c]) begin
          latest[c] <= meas_value;
          // a triggering sample joins the average only when folding is on
          if (!hit[c] || cfg[c][wakeup_measure_compare_pkg::FOLD_BIT]) begin
            mean[c] <= next_mean[c];
          end
        end
      end
    end
  end

  // ****************************************************************
  // interrupt status (write one to clear, set wins) and output
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= 3'h0;
    end else if (set_default) begin
      irq_status <= 3'h0;
    end else begin
      irq_status <= (irq_status &
                     ~((commit_wr && addr_ok &&
                        idx == wakeup_measure_compare_pkg::IRQ_STATUS_IDX) ? pwdata[2:0] : 3'h0))
                    | (take_ch & hit);
    end
  end

  // level interrupt while an unmasked status bit is set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_mask);
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic [7:0] phs_thr;
  logic [7:0] cap_thr;
  assign phs_thr = {4'h0, cfg[1][7:4]};
  assign cap_thr = {4'h0, cfg[2][7:4]};

  property p_phase_hit;
    take && meas_channel == 2'h1 && abs_diff[1] > phs_thr && !set_default |=> irq_status[1];
  endproperty
  a_phase_hit: assert property (p_phase_hit) else $error("phase trigger lost");

  property p_cap_hit;
    take && meas_channel == 2'h2 && abs_diff[2] > cap_thr && !set_default |=> irq_status[2];
  endproperty
  a_cap_hit: assert property (p_cap_hit) else $error("capacitance trigger lost");

  property p_no_fold;
    take && hit[0] && meas_channel == 2'h0 && !cfg[0][3] && !set_default
      |=> $stable(mean[0]);
  endproperty
  a_no_fold: assert property (p_no_fold) else $error("excluded sample changed mean");

  property p_mean_step;
    take && meas_channel == 2'h1 && (!hit[1] || cfg[1][3]) && !set_default
      |=> mean[1] == $past(next_mean[1]);
  endproperty
  a_mean_step: assert property (p_mean_step) else $error("mean update wrong");

  property p_stored_ref;
    take && meas_channel == 2'h1 && !cfg[1][0] && meas_value == baseline[1]
      |=> !$rose(irq_status[1]);
  endproperty
  a_stored_ref: assert property (p_stored_ref) else $error("match raised phase trigger");

  property p_amp_ref_write;
    commit_wr && addr_ok && idx == wakeup_measure_compare_pkg::AMP_REF_IDX
      |=> baseline[0] == $past(pwdata[7:0]);
  endproperty
  a_amp_ref_write: assert property (p_amp_ref_write) else $error("amp reference not written");

  property p_default_clear;
    set_default |=> cfg[1] == 8'h00 && baseline[0] == 8'h00 && mean[2] == 8'h00
                    && latest[0] == 8'h00;
  endproperty
  a_default_clear: assert property (p_default_clear) else $error("default left state");

  property p_result_view;
    take && !set_default |=> latest[$past(meas_channel)] == $past(meas_value);
  endproperty
  a_result_view: assert property (p_result_view) else $error("result view stale");

  property p_sequence_start;
    seq_state == wakeup_measure_compare_pkg::seq_idle && timer_expiry && wake_enable != 3'h0
      && !set_default |-> ##2 (meas_start || $past(set_default));
  endproperty
  a_sequence_start: assert property (p_sequence_start) else $error("no measurement issued");

  // a sample equal to the capacitance running average never triggers while bit 0 selects the average
  property p_cap_source;
    take && meas_channel == 2'h2 && cfg[2][0] && meas_value == mean[2]
      |=> !$rose(irq_status[2]);
  endproperty
  a_cap_source: assert property (p_cap_source) else $error("average match triggered");

  // software writes never reach the read-only views
  property p_avg_view_ro;
    commit_wr && idx == wakeup_measure_compare_pkg::AMP_AVG_IDX && !take_ch[0]
      |=> $stable(mean[0]);
  endproperty
  a_avg_view_ro: assert property (p_avg_view_ro) else $error("average view written");

  property p_phs_res_ro;
    commit_wr && idx == wakeup_measure_compare_pkg::PHS_RES_IDX && !take_ch[1]
      |=> $stable(latest[1]);
  endproperty
  a_phs_res_ro: assert property (p_phs_res_ro) else $error("phase view written");

  // set-default clears the result and average views too
  property p_default_views;
    set_default |=> mean[0] == 8'h00 && mean[1] == 8'h00 && latest[1] == 8'h00
                    && latest[2] == 8'h00;
  endproperty
  a_default_views: assert property (p_default_views) else $error("views not cleared");

  c_phase_trigger: cover property (take && meas_channel == 2'h1 && hit[1]);
  c_all_three:     cover property (timer_expiry && wake_enable == 3'h7);
  c_irq_high:      cover property (!irq ##1 irq);
  c_fold_in:       cover property (take && hit[0] && cfg[0][3]);
  c_set_default:   cover property (set_default);

endmodule : wakeup_measure_compare

// file: testbench/wakeup_measure_compare_tb_top.sv
`timescale 1ns/1ps

// ****************************************************************
// self-checking bench for the wake-up compare block
// ****************************************************************
module wakeup_measure_compare_tb_top;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic        timer_expiry;
  logic        meas_done;
  logic [7:0]  meas_value;
  logic        meas_start;
  logic [1:0]  meas_channel;
  logic        irq;
  int          err_count;
  int          n_tests;
  int          cycles;
  int          n_starts;
  int          n_before;
  int          n_served;
  logic [31:0] seed = 32'h0000_2B9A;
  logic [31:0] rd_data;
  logic        rd_err;
  logic [7:0]  m_cfg [3];
  logic [7:0]  m_ref [3];
  logic [7:0]  m_avg [3];
  logic [2:0]  m_stat;

  wakeup_measure_compare wakeup_measure_compare_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .timer_expiry(timer_expiry), .meas_done(meas_done), .meas_value(meas_value),
    .meas_start(meas_start), .meas_channel(meas_channel), .irq(irq)
  );

  // 200 MHz clock
  always #2.5 pclk = ~pclk;

  // hang guard and measurement request counter
  always @(posedge pclk) begin
    cycles++;
    if (meas_start === 1'b1) n_starts++;
    if (cycles == 20000) begin
      err_count++;
      end_sim();
    end
  end

  // xorshift source, fixed start value
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  // register index of a channel: k 0 cfg, 1 ref, 2 avg, 3 result
  function automatic logic [7:0] ri(input int ch, input int k);
    return 8'(8'h32 + 4 * ch + k);
  endfunction : ri

  function automatic logic [7:0] clip(input int x);
    return (x < 0) ? 8'h00 : (x > 255) ? 8'hFF : 8'(x);
  endfunction : clip

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [1:0] off,
                     input logic [31:0] wd);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= {2'b00, idx, off};
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd_data = prdata;
    rd_err  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    apb(1'b1, idx, 2'b00, d);
  endtask : wr

  task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 2'b00, 32'h0000_0000);
    check(rd_data, exp);
    check({31'h0, rd_err}, 32'h0000_0000);
  endtask : rdc

  task automatic all_zero();
    for (int i = 0; i < 15; i++) rdc((i < 12) ? ri(0, i) : ri(0, i + 2), 32'h0000_0000);
  endtask : all_zero

  task automatic expire();
    @(posedge pclk);
    timer_expiry <= 1'b1;
    @(posedge pclk);
    timer_expiry <= 1'b0;
  endtask : expire

  // answer the next measurement request; the pulse is counted above, so one
  // that rises during a register read is still served
  task automatic serve(input int ch, input logic [7:0] v);
    do @(posedge pclk); while (n_starts == n_served);
    n_served++;
    check({30'h0, meas_channel}, 32'(ch));
    meas_done  <= 1'b1;
    meas_value <= v;
    @(posedge pclk);
    meas_done  <= 1'b0;
    meas_value <= ~v;
  endtask : serve

  // expected compare, status and average after one sample
  task automatic model(input int ch, input logic [7:0] v);
    int   d;
    int   th;
    logic trig;
    d = int'(v) - int'(m_cfg[ch][0] ? m_avg[ch] : m_ref[ch]);
    th = int'(m_cfg[ch][7:4]);
    trig = (d > th) || (-d > th);
    if (trig) m_stat[ch] = 1'b1;
    d = (int'(v) - int'(m_avg[ch])) >>> (2 + int'(m_cfg[ch][2:1]));
    if (!trig || m_cfg[ch][3]) m_avg[ch] = 8'(int'(m_avg[ch]) + d);
  endtask : model

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_sim

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    logic [31:0] t;
    int          eff;
    int          th;
    logic [7:0]  v;
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, timer_expiry, meas_done} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    meas_value = 8'h00;
    m_stat = 3'h0;
    for (int c = 0; c < 3; c++) m_avg[c] = 8'h00;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    all_zero();
    for (int i = 0; i < 12; i++) wr(ri(0, i), 32'(8'hA0 + i));
    for (int i = 0; i < 12; i++) rdc(ri(0, i), (i % 4 >= 2) ? 0 : 32'(8'hA0 + i));
    apb(1'b0, 8'h50, 2'b00, 32'h0000_0000);
    check({31'h0, rd_err}, 32'h0000_0001);
    apb(1'b1, ri(0, 1), 2'b10, 32'h0000_00FF);
    check({31'h0, rd_err}, 32'h0000_0001);
    rdc(ri(0, 1), 32'h0000_00A1);
    // expiry with nothing enabled starts no measurement
    wr(wakeup_measure_compare_pkg::WAKE_CTRL_IDX, 32'h0000_0000);
    n_before = n_starts;
    expire();
    repeat (8) @(posedge pclk);
    check(32'(n_starts), 32'(n_before));
    for (int r = 0; r < 12; r++) begin
      for (int ch = 0; ch < 3; ch++) begin
        t = xs();
        m_cfg[ch] = {t[7:3], 2'(r + ch), t[0]};
        m_ref[ch] = t[15:8];
        wr(ri(ch, 0), {24'h0, m_cfg[ch]});
        wr(ri(ch, 1), {24'h0, m_ref[ch]});
      end
      wr(wakeup_measure_compare_pkg::WAKE_CTRL_IDX, 32'h0000_0007);
      wr(wakeup_measure_compare_pkg::IRQ_MASK_IDX, (r % 3 == 0) ? 0 : 32'h0000_0007);
      expire();
      for (int ch = 0; ch < 3; ch++) begin
        t = xs();
        eff = int'(m_cfg[ch][0] ? m_avg[ch] : m_ref[ch]);
        th = int'(m_cfg[ch][7:4]);
        case (t[9:8])
          2'h0: v = t[7:0];
          2'h1: v = clip(eff + th);
          2'h2: v = clip(eff + th + 1);
          default: v = clip(eff - th - 1);
        endcase
        serve(ch, v);
        model(ch, v);
        repeat (3) @(posedge pclk);
        rdc(ri(ch, 3), {24'h0, v});
      end
      for (int ch = 0; ch < 3; ch++) rdc(ri(ch, 2), {24'h0, m_avg[ch]});
      rdc(wakeup_measure_compare_pkg::IRQ_STATUS_IDX, {29'h0, m_stat});
      check({31'h0, irq}, {31'h0, (r % 3 != 0) && (m_stat != 3'h0)});
      wr(wakeup_measure_compare_pkg::IRQ_STATUS_IDX, {29'h0, m_stat});
      m_stat = 3'h0;
      rdc(wakeup_measure_compare_pkg::IRQ_STATUS_IDX, 32'h0000_0000);
      repeat (2) @(posedge pclk);
      check({31'h0, irq}, 32'h0000_0000);
    end
    // set-default command clears everything again
    wr(wakeup_measure_compare_pkg::COMMAND_IDX, 32'h0000_0001);
    all_zero();
    end_sim();
  end

endmodule : wakeup_measure_compare_tb_top
